// file: hdl/pod_pkg.sv
package pod_pkg;

  // Register byte offsets
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_MASK    = 12'h008;
  localparam logic [11:0] ADDR_STATE   = 12'h00C;
  localparam logic [11:0] ADDR_PRESS   = 12'h010;
  localparam logic [11:0] ADDR_DAC     = 12'h014;
  localparam logic [11:0] ADDR_GAIN    = 12'h018;
  localparam logic [11:0] ADDR_OFFSET  = 12'h01C;

  // Status and mask bit positions
  localparam int ST_BRIDGE  = 0;
  localparam int ST_SUPPLY  = 1;
  localparam int ST_CRC     = 2;
  localparam int ST_READY   = 3;
  localparam int ST_WIDTH   = 4;

  // Control bit positions
  localparam int CTRL_FORCE_CHECK = 0;

  // Nominal calibration, Q16: gain 0.80 %/kPa, offset -2.0 %
  localparam logic [31:0] GAIN_RESET   = 32'h0000_CCCD;
  localparam logic [31:0] OFFSET_RESET = 32'hFFFE_0000;

  // Window thresholds as fractions of bridge supply, in 1/256
  localparam logic [7:0] WIN_LOW_FRAC  = 8'h40;
  localparam logic [7:0] WIN_HIGH_FRAC = 8'hC0;

  // Timing: clock 40 MHz
  localparam int CLK_MHZ           = 40;
  localparam int STARTUP_DELAY_US  = 5000;
  localparam int STEP_RESPONSE_US  = 1000;
  localparam int SETTLING_TIME_US  = 10000;
  localparam int STARTUP_CYCLES    = STARTUP_DELAY_US * CLK_MHZ;
  localparam int STEP_CYCLES       = STEP_RESPONSE_US * CLK_MHZ;
  localparam int SETTLE_CYCLES     = SETTLING_TIME_US * CLK_MHZ;
  localparam int DEBOUNCE_CYCLES   = 16;
  localparam int CRC_POLY          = 16'h1021;

  // Supervisor states
  typedef enum logic [2:0] {POD_CRC_RUN, POD_CRC_CHECK, POD_RUN, POD_IDLE} pod_state_t;

  // Bridge sample group
  typedef struct packed {
    logic [15:0] signal_pos;
    logic [15:0] signal_neg;
    logic [15:0] supply;
  } pod_bridge_t;

endpackage

// file: hdl/pod_top.sv
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module pod_top #(
  parameter int MEM_WORDS      = 16,
  parameter int STARTUP_CYCLES = pod_pkg::STARTUP_CYCLES,
  parameter int DEBOUNCE       = pod_pkg::DEBOUNCE_CYCLES
) (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Configuration memory read port
  output logic      [7:0]         mem_addr,
  input  wire logic [31:0]        mem_rdata,
  // Bridge samples from converter, same clock
  input  wire pod_pkg::pod_bridge_t bridge,
  input  wire logic               supply_ok_pin,
  input  wire logic [15:0]        pressure_kpa_q8,
  input  wire logic               pressure_valid,
  // Analog output control
  output logic      [15:0]        dac_code,
  output logic                    out_ground,
  output logic                    out_hiz,
  output logic                    sink_enable,
  output logic                    irq
);

  localparam int ST_WIDTH_L = pod_pkg::ST_WIDTH;
  pod_pkg::pod_state_t state;
  logic [31:0] gain_coefficient;
  logic [31:0] offset_coefficient;
  logic [15:0] crc;
  logic [15:0] crc_stored;
  logic [7:0]  widx;
  logic [31:0] start_cnt;
  logic [7:0]  deb_cnt;
  logic        bridge_err;
  logic        supply_err;
  logic [1:0]  sup_sync;
  logic [ST_WIDTH_L-1:0] status;
  logic [ST_WIDTH_L-1:0] mask;
  logic        ctrl_force;

  // Window comparators on both bridge inputs
  wire [23:0] lo_lim = bridge.supply * pod_pkg::WIN_LOW_FRAC;
  wire [23:0] hi_lim = bridge.supply * pod_pkg::WIN_HIGH_FRAC;
  wire [23:0] pos_s  = {bridge.signal_pos, 8'h00};
  wire [23:0] neg_s  = {bridge.signal_neg, 8'h00};
  wire pos_bad = (pos_s < lo_lim) || (pos_s > hi_lim);
  wire neg_bad = (neg_s < lo_lim) || (neg_s > hi_lim);
  wire win_fault = pos_bad | neg_bad;
  wire running = (state == pod_pkg::POD_RUN);

  // Bridge sinks on from reset onward
  assign sink_enable = 1'b1;

  // CRC next value for one word
  function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [31:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ 16'(pod_pkg::CRC_POLY)) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  // Supply-ok pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_sync <= 2'h0;
    end else begin
      sup_sync <= {sup_sync[0], supply_ok_pin};
    end
  end

  // Power-up CRC walk then run or idle
  assign mem_addr = widx;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state              <= pod_pkg::POD_CRC_RUN;
      widx               <= 8'h00;
      crc                <= 16'hFFFF;
      crc_stored         <= 16'h0000;
      gain_coefficient   <= pod_pkg::GAIN_RESET;
      offset_coefficient <= pod_pkg::OFFSET_RESET;
    end else begin
      case (state)
        pod_pkg::POD_CRC_RUN: begin
          if (widx == 8'(MEM_WORDS - 1)) begin
            crc_stored <= mem_rdata[15:0];
            state      <= pod_pkg::POD_CRC_CHECK;
          end else begin
            crc  <= crc_word(crc, mem_rdata);
            widx <= widx + 8'h01;
            if (widx == 8'h00) gain_coefficient <= mem_rdata;
            if (widx == 8'h01) offset_coefficient <= mem_rdata;
          end
        end
        pod_pkg::POD_CRC_CHECK: begin
          state <= (crc == crc_stored) ? pod_pkg::POD_RUN : pod_pkg::POD_IDLE;
        end
        pod_pkg::POD_RUN: state <= pod_pkg::POD_RUN;
        pod_pkg::POD_IDLE: state <= pod_pkg::POD_IDLE;
        default: state <= pod_pkg::POD_IDLE;
      endcase
    end
  end

  // Debounce filter and error flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deb_cnt    <= 8'h00;
      bridge_err <= 1'b0;
      supply_err <= 1'b0;
    end else begin
      if (win_fault) begin
        deb_cnt <= (deb_cnt == 8'(DEBOUNCE)) ? deb_cnt : deb_cnt + 8'h01;
      end else begin
        deb_cnt <= 8'h00;
      end
      bridge_err <= (deb_cnt == 8'(DEBOUNCE)) || ctrl_force;
      supply_err <= ~sup_sync[1];
    end
  end

  // Linear transfer: Q16 gain times Q8 kPa plus offset, in 1/65536 of a percent of supply
  wire signed [63:0] prod = $signed({32'h0, gain_coefficient}) * $signed({48'h0, pressure_kpa_q8});
  wire signed [63:0] pct  = (prod >>> 8) + {{32{offset_coefficient[31]}}, offset_coefficient};
  // Percent of supply scaled down to a plain fraction of supply
  wire signed [63:0] frac = pct / 64'sd100;
  wire [15:0] next_dac = frac[63] ? 16'h0000 :
                         (frac > 64'sh0000_FFFF) ? 16'hFFFF : frac[15:0];

  // DAC register, written only while running; direct path keeps 1 ms response
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_code  <= 16'h0000;
      start_cnt <= 32'h0;
    end else begin
      if (running && pressure_valid) dac_code <= next_dac;
      if (running && start_cnt != 32'(STARTUP_CYCLES)) start_cnt <= start_cnt + 32'h1;
    end
  end

  // Output state; high impedance outranks ground
  assign out_hiz    = (state == pod_pkg::POD_IDLE);
  assign out_ground = ~out_hiz & (bridge_err | supply_err);

  // APB decode
  wire acc = psel & penable;
  wire wr  = acc & pwrite;
  wire rd  = acc & ~pwrite;
  wire hit_ctrl   = (paddr == pod_pkg::ADDR_CTRL);
  wire hit_status = (paddr == pod_pkg::ADDR_STATUS);
  wire hit_mask   = (paddr == pod_pkg::ADDR_MASK);
  wire hit_state  = (paddr == pod_pkg::ADDR_STATE);
  wire hit_press  = (paddr == pod_pkg::ADDR_PRESS);
  wire hit_dac    = (paddr == pod_pkg::ADDR_DAC);
  wire hit_gain   = (paddr == pod_pkg::ADDR_GAIN);
  wire hit_off    = (paddr == pod_pkg::ADDR_OFFSET);
  wire mapped = hit_ctrl | hit_status | hit_mask | hit_state | hit_press
              | hit_dac | hit_gain | hit_off;
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  // Ready bit rises once the startup interval has run out
  wire started = running && (start_cnt == 32'(STARTUP_CYCLES));
  wire [3:0] events = {started, state == pod_pkg::POD_IDLE, supply_err, bridge_err};
  wire [31:0] rd_mux =
      hit_ctrl   ? {31'h0, ctrl_force} :
      hit_status ? {28'h0, status} :
      hit_mask   ? {28'h0, mask} :
      hit_state  ? {29'h0, state} :
      hit_press  ? {16'h0, pressure_kpa_q8} :
      hit_dac    ? {14'h0, out_hiz, out_ground, dac_code} :
      hit_gain   ? gain_coefficient :
      hit_off    ? offset_coefficient : 32'h0;

  // Register writes, sticky status cleared by read, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_force <= 1'b0;
      mask       <= '0;
      status     <= '0;
      prdata     <= 32'h0;
    end else begin
      if (wr && hit_ctrl) ctrl_force <= pwdata[pod_pkg::CTRL_FORCE_CHECK];
      if (wr && hit_mask) mask <= pwdata[ST_WIDTH_L-1:0];
      status <= ((rd && hit_status) ? '0 : status) | events;
      if (psel && !penable && !pwrite) prdata <= rd_mux;
    end
  end

  assign irq = |(status & mask);

endmodule
`default_nettype wire

// file: test/pod_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module pod_assertions #(
  parameter int MEM_WORDS      = 16,
  parameter int STARTUP_CYCLES = 16,
  parameter int DEBOUNCE       = 4
) (
  // Clock, reset and bus
  input wire logic                 pclk, presetn, psel, penable, pready, pslverr,
  input wire logic [11:0]          paddr,
  // Sensor side
  input wire pod_pkg::pod_bridge_t bridge,
  input wire logic                 supply_ok_pin, pressure_valid,
  // Output control
  input wire logic [15:0]          dac_code,
  input wire logic                 out_ground, out_hiz, sink_enable
);
  // Window limits and fault of either bridge input
  wire logic [23:0] lo = bridge.supply * pod_pkg::WIN_LOW_FRAC;
  wire logic [23:0] hi = bridge.supply * pod_pkg::WIN_HIGH_FRAC;
  wire logic        wf = ({bridge.signal_pos, 8'h00} < lo) || ({bridge.signal_pos, 8'h00} > hi)
                      || ({bridge.signal_neg, 8'h00} < lo) || ({bridge.signal_neg, 8'h00} > hi);
  logic [7:0]       run_len;
  // Consecutive cycles with a window fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_len <= 8'h00;
    else if (!wf) run_len <= 8'h00;
    else if (run_len != 8'hFF) run_len <= run_len + 8'h01;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_supply_lost; !supply_ok_pin [*3]; endsequence
  sequence s_bridge_held; run_len == 8'(DEBOUNCE + 1); endsequence
  a_pready_high: assert property (pready) else $error("pready low");
  a_sink_on: assert property (sink_enable) else $error("bridge sinks off");
  a_bridge_ground: assert property (s_bridge_held |-> ##[0:3] (out_ground || out_hiz))
    else $error("bridge fault not grounded");
  a_supply_ground: assert property (s_supply_lost |-> ##[0:3] (out_ground || out_hiz))
    else $error("supply fault not grounded");
  a_hiz_freeze: assert property (out_hiz |-> $stable(dac_code))
    else $error("output code moved while idle");
  a_hiz_sticky: assert property (out_hiz |=> out_hiz) else $error("float released");
  a_dac_cause: assert property ($changed(dac_code) |-> $past(pressure_valid))
    else $error("output code moved without sample");
  a_unmapped_err: assert property (psel && penable && paddr > pod_pkg::ADDR_OFFSET |-> pslverr)
    else $error("unmapped access accepted");
endmodule
`default_nettype wire

// file: test/pod_rx_model.sv
`timescale 1ns/10ps
`default_nettype none
module pod_rx_model (
  // Output control seen as an analog level
  input wire logic [15:0] dac_code,
  input wire logic        out_ground, out_hiz,
  // Level in 1/65536 of supply and range flag
  output logic [16:0]     aout_level,
  output logic            out_of_range
);
  // Pull-up resistor lifts a floating output to full supply
  assign aout_level = out_hiz ? 17'h10000 : (out_ground ? 17'h00000 : {1'b0, dac_code});
  // Regular range lies between the clipping levels
  assign out_of_range = (aout_level < 17'h0199A) || (aout_level > 17'h0E666);
endmodule
`default_nettype wire

// file: test/pod_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pod_top_tb;
  localparam int MW = 16, DB = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, supply_ok_pin, pressure_valid;
  logic out_ground, out_hiz, sink_enable, irq, oor, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, mem_rdata;
  logic [31:0] mem [0:15];
  logic [7:0]  mem_addr;
  logic [15:0] pressure_kpa_q8, dac_code, pk;
  logic [16:0] lvl;
  pod_pkg::pod_bridge_t bridge;
  int n_errors = 0, checks_done = 0, cyc = 0;
  pod_top #(.MEM_WORDS(MW), .STARTUP_CYCLES(16), .DEBOUNCE(DB)) u_pod_top (.*);
  pod_rx_model u_pod_rx_model (.dac_code, .out_ground, .out_hiz, .aout_level(lvl),
    .out_of_range(oor));
  assign mem_rdata = mem[mem_addr[3:0]];
  // Clock and hang limit
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [15:0] crc_calc();
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < MW - 1; i++)
      for (int b = 31; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ mem[i][b]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  function automatic logic [15:0] dac_exp(input logic [15:0] p);
    longint pct;
    pct = longint'(mem[0]) * p / 256 + longint'(signed'(mem[1]));
    return 16'(pct / 100);
  endfunction
  task automatic start(input logic bad, input logic [2:0] want);
    mem[15] = {16'h0000, crc_calc() ^ {15'h0000, bad}};
    bridge <= '{16'h4000, 16'h4000, 16'h8000};
    supply_ok_pin <= 1'b1;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      apb(1'b0, pod_pkg::ADDR_STATE, 32'h0);
      if (rd[2:0] === want) break;
    end
    chk(rd[2:0] === want, "startup state");
  endtask
  task automatic press(input logic [15:0] p);
    pressure_kpa_q8 <= p;
    pressure_valid <= 1'b1;
    @(posedge pclk) pressure_valid <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; supply_ok_pin = 1'b1; pressure_valid = 1'b0; pressure_kpa_q8 = 16'h0;
    bridge = '{16'h4000, 16'h4000, 16'h8000};
    void'($urandom(32'hda4eb2c2));
    foreach (mem[i]) mem[i] = $urandom();
    for (int c = 0; c < 2; c++) begin
      mem[0] = c ? 32'h0000_8000 : pod_pkg::GAIN_RESET;
      mem[1] = c ? 32'h0005_0000 : pod_pkg::OFFSET_RESET;
      @(posedge pclk);
      start(1'b0, 3'(pod_pkg::POD_RUN));
      chk(out_hiz === 1'b0, "output floating");
      apb(1'b0, pod_pkg::ADDR_GAIN, 32'h0);
      chk(rd === mem[0], "gain readback");
      repeat (8) begin
        pk = 16'(3840 + $urandom_range(25600));
        press(pk);
        chk(16'(dac_code - dac_exp(pk) + 16'h2) <= 16'h4, "output code");
      end
    end
    $display("Test transfer done");
    // Glitch shorter than the filter, then a held fault
    bridge.signal_pos <= 16'h1000;
    repeat (DB - 1) @(posedge pclk);
    bridge.signal_pos <= 16'h4000;
    repeat (4) @(posedge pclk);
    chk(out_ground === 1'b0, "glitch grounded");
    apb(1'b1, pod_pkg::ADDR_MASK, 32'h0);
    bridge.signal_neg <= 16'h7000;
    repeat (DB + 4) @(posedge pclk);
    chk(out_ground === 1'b1 && lvl === 17'h0 && irq === 1'b0, "bridge fault");
    apb(1'b1, pod_pkg::ADDR_MASK, 32'hF);
    chk(irq === 1'b1, "irq unmasked");
    apb(1'b0, pod_pkg::ADDR_STATUS, 32'h0);
    chk(rd[0] === 1'b1, "bridge status");
    $display("Test bridge done");
    // Supply loss, status clear and unmapped access
    start(1'b0, 3'(pod_pkg::POD_RUN));
    supply_ok_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(out_ground === 1'b1 && lvl === 17'h0, "supply fault");
    supply_ok_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, pod_pkg::ADDR_STATUS, 32'h0);
    chk(rd[1] === 1'b1, "supply status");
    chk(irq === 1'b0, "irq after clear");
    apb(1'b0, 12'h020, 32'h0);
    chk(er === 1'b1 && rd === 32'h0, "unmapped read");
    $display("Test supply done");
    // Bad checksum with faults on top
    start(1'b1, 3'(pod_pkg::POD_IDLE));
    press(16'h4000);
    bridge.signal_pos <= 16'h1000;
    supply_ok_pin <= 1'b0;
    repeat (DB + 4) @(posedge pclk);
    chk(out_hiz === 1'b1 && dac_code === 16'h0, "idle output");
    chk(lvl === 17'h10000 && oor === 1'b1, "receiver level");
    $display("Test checksum done");
    report_and_stop();
  end
endmodule
bind pod_top pod_assertions #(.MEM_WORDS(MEM_WORDS), .STARTUP_CYCLES(STARTUP_CYCLES),
  .DEBOUNCE(DEBOUNCE)) u_pod_assertions (.*);
`default_nettype wire
